// ### design/analog_input_readout_consts.svh
`ifndef ANALOG_INPUT_READOUT_CONSTS_SVH
`define ANALOG_INPUT_READOUT_CONSTS_SVH
`define ADDR_RESULT_CH0 16'h0320
`define ADDR_RESULT_CH1 16'h0322
`define PARAM_RECORD_NUM 8'h01
`define FILTER_SELECT_RESET 8'h10
`define SEL_CH0_LSB 0
`define SEL_CH1_LSB 2
`define SELECT_INVALID_MASK 8'he0
`define SIGN_BIT 15
`define RES_LSB_MASK 16'hfff0
`define CODE_POS_SAT 16'h7fff
`define CODE_NEG_SAT 16'h8000
`define FULL_SCALE_CODE 32'sd27648
`define NOMINAL_MV 32'sd10000
`define OVERDRIVE_MV 32'sd11759
`define UNDERDRIVE_MV (-32'sd800)
`define FILTER_SHIFT 3
`define CLOCK_MHZ 40
`define APPLY_MAX_US 2000
`define INT_SEL0_US 2500
`define INT_SEL1_US 20000
`define INT_SEL2_US 100000
`define INT_SEL3_US 1000000
`define INT_DEFAULT_US 1000000
`endif

// ### design/analog_input_readout_pkg.sv
package analog_input_readout_pkg;
  typedef enum logic {ApplyIdle, ApplyBusy} apply_state_e;
  typedef logic [1:0] int_sel_t;
  typedef logic signed [15:0] milli_volt_t;
endpackage

// ### design/analog_input_readout.sv
`timescale 1ns/10ps
`include "analog_input_readout_consts.svh"

module analog_input_readout
  import analog_input_readout_pkg::*;
#(
  parameter int INT_CYC0 = `INT_SEL0_US * `CLOCK_MHZ,
  parameter int INT_CYC1 = `INT_SEL1_US * `CLOCK_MHZ,
  parameter int INT_CYC2 = `INT_SEL2_US * `CLOCK_MHZ,
  parameter int INT_CYC3 = `INT_SEL3_US * `CLOCK_MHZ,
  parameter int DEFAULT_CYC = `INT_DEFAULT_US * `CLOCK_MHZ,
  parameter int APPLY_CYC = `APPLY_MAX_US * `CLOCK_MHZ
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sampleValid,
  input wire logic sampleChannel,
  input wire logic signed [15:0] sampleMilliVolts,
  input wire logic parmWrite,
  input wire logic [7:0] parmRecordNum,
  input wire logic [7:0] parmByte0,
  input wire logic [7:0] parmByte1,
  output logic parmAccepted,
  output logic applying,
  input wire logic readEnable,
  input wire logic [15:0] readAddress,
  output logic [15:0] readData,
  output logic readValid
);

  // Millivolts to left-justified code with range limits
  function automatic logic [15:0] scaleCode(input milli_volt_t mv);
    logic signed [31:0] wide;
    logic signed [31:0] prod;
    wide = 32'(mv);
    prod = (wide * `FULL_SCALE_CODE) / `NOMINAL_MV;
    if (wide > `OVERDRIVE_MV) begin
      scaleCode = `CODE_POS_SAT;
    end else if (wide < `UNDERDRIVE_MV) begin
      scaleCode = `CODE_NEG_SAT;
    end else begin
      scaleCode = prod[15:0] & `RES_LSB_MASK;
    end
  endfunction

  function automatic logic [31:0] periodLast(input logic cfg, input int_sel_t sel);
    logic [31:0] n;
    n = 32'(DEFAULT_CYC);
    if (cfg) begin
      unique case (sel)
        2'b00: n = 32'(INT_CYC0);
        2'b01: n = 32'(INT_CYC1);
        2'b10: n = 32'(INT_CYC2);
        2'b11: n = 32'(INT_CYC3);
      endcase
    end
    periodLast = n - 32'd1;
  endfunction

  apply_state_e applyState_r;
  logic [31:0] applyCnt_r;
  logic [7:0] pendingSel_r;
  logic [7:0] filterSel_r;
  logic configured_r;
  logic paramInvalid;
  logic [31:0] periodCnt_r [2];
  logic periodEnd [2];
  int_sel_t chanSel [2];
  milli_volt_t filt_r [2];
  logic [15:0] result_r [2];

  // Byte 0 and trailing bytes carry nothing; only byte 1 is kept
  assign parmAccepted = parmWrite && (parmRecordNum == `PARAM_RECORD_NUM);
  assign applying = (applyState_r == ApplyBusy);
  assign paramInvalid = |(filterSel_r & `SELECT_INVALID_MASK);
  assign chanSel[0] = filterSel_r[`SEL_CH0_LSB +: 2];
  assign chanSel[1] = filterSel_r[`SEL_CH1_LSB +: 2];

  // A new record during apply restarts the wait with the newest byte
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      applyState_r <= ApplyIdle;
      applyCnt_r <= 32'd0;
      pendingSel_r <= `FILTER_SELECT_RESET;
    end else if (parmAccepted) begin
      applyState_r <= ApplyBusy;
      applyCnt_r <= 32'd0;
      pendingSel_r <= parmByte1;
    end else begin
      unique case (applyState_r)
        ApplyIdle: applyCnt_r <= 32'd0;
        ApplyBusy: begin
          applyCnt_r <= applyCnt_r + 32'd1;
          if (applyCnt_r == 32'(APPLY_CYC - 1)) begin
            applyState_r <= ApplyIdle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filterSel_r <= `FILTER_SELECT_RESET;
      configured_r <= 1'b0;
    end else if (applying && !parmAccepted && applyCnt_r == 32'(APPLY_CYC - 1)) begin
      filterSel_r <= pendingSel_r;
      configured_r <= 1'b1;
    end
  end

  // Integration periods restart once settings land, one timer per channel
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      periodCnt_r[0] <= 32'd0;
      periodCnt_r[1] <= 32'd0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (applying || periodEnd[c]) begin
          periodCnt_r[c] <= 32'd0;
        end else begin
          periodCnt_r[c] <= periodCnt_r[c] + 32'd1;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      periodEnd[c] = !applying && (periodCnt_r[c] == periodLast(configured_r, chanSel[c]));
    end
  end

  // First-order smoothing; cheaper than a true mean with a divider
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      filt_r[0] <= 16'sd0;
      filt_r[1] <= 16'sd0;
    end else if (sampleValid) begin
      for (int c = 0; c < 2; c++) begin
        if (sampleChannel == 1'(c)) begin
          filt_r[c] <= filt_r[c] + 16'((17'(sampleMilliVolts) - 17'(filt_r[c]))
                       >>> `FILTER_SHIFT);
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      result_r[0] <= 16'h0000;
      result_r[1] <= 16'h0000;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (periodEnd[c]) begin
          if (paramInvalid) begin
            result_r[c] <= `CODE_POS_SAT;
          end else begin
            result_r[c] <= scaleCode(filt_r[c]);
          end
        end
      end
    end
  end

  // Unmapped addresses answer zero so software sees a defined word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readData <= 16'h0000;
      readValid <= 1'b0;
    end else begin
      readValid <= readEnable;
      if (!readEnable) begin
        readData <= readData;
      end else if (readAddress == `ADDR_RESULT_CH0) begin
        readData <= applying ? `CODE_POS_SAT : result_r[0];
      end else if (readAddress == `ADDR_RESULT_CH1) begin
        readData <= applying ? `CODE_POS_SAT : result_r[1];
      end else begin
        readData <= 16'h0000;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence applyStart;
    parmAccepted ##1 applying;
  endsequence

  sequence applyDone;
    !applying ##1 (filterSel_r == $past(pendingSel_r));
  endsequence

  chk_ch0_read: assert property (readEnable && readAddress == `ADDR_RESULT_CH0
    && !applying |=> readValid && readData == $past(result_r[0]))
    else $error("channel 0 word not returned");

  chk_ch1_read: assert property (readEnable && readAddress == `ADDR_RESULT_CH1
    && !applying |=> readValid && readData == $past(result_r[1]))
    else $error("channel 1 word not returned");

  chk_sign_neg: assert property (periodEnd[0] && !paramInvalid
    && filt_r[0] < 0 |=> result_r[0][`SIGN_BIT])
    else $error("negative value without sign bit");

  chk_low_bits: assert property (periodEnd[1] && !paramInvalid
    && filt_r[1] <= 16'sd11759 |=> result_r[1][3:0] == 4'h0)
    else $error("low bits not zero");

  chk_over_sat: assert property (periodEnd[0] && !paramInvalid
    && filt_r[0] > 16'sd11759 |=> result_r[0] == 16'h7fff)
    else $error("overflow code missing");

  chk_under_sat: assert property (periodEnd[1] && !paramInvalid
    && filt_r[1] < -16'sd800 |=> result_r[1] == 16'h8000)
    else $error("underflow code missing");

  chk_invalid_code: assert property (periodEnd[0] && paramInvalid
    |=> result_r[0] == 16'h7fff)
    else $error("invalid parameter code missing");

  // Filter reaches an exact level only from above, so channel 0 gets it
  chk_nominal_scale: assert property (periodEnd[0] && !paramInvalid
    && filt_r[0] == 16'sd10000 |=> result_r[0] == 16'h6c00)
    else $error("nominal scaling wrong");

  chk_default_period: assert property (!configured_r && !applying
    |-> periodCnt_r[0] < 32'(DEFAULT_CYC))
    else $error("default period exceeded");

  chk_record_take: assert property (parmWrite && parmRecordNum == 8'h01
    |-> applyStart)
    else $error("record 1 not accepted");

  chk_apply_bound: assert property (applying |-> applyCnt_r < 32'(APPLY_CYC))
    else $error("apply longer than allowed");

  chk_apply_end: assert property (applying && !parmAccepted
    && applyCnt_r == 32'(APPLY_CYC - 1) |=> applyDone)
    else $error("new settings not applied");

  chk_apply_code: assert property (readEnable && applying
    && readAddress == `ADDR_RESULT_CH1 |=> readData == 16'h7fff)
    else $error("apply code not shown");

  chk_fast_period: assert property (configured_r && chanSel[0] == 2'b00
    && periodEnd[0] |-> periodCnt_r[0] == 32'(INT_CYC0 - 1))
    else $error("2.5ms period wrong");

  chk_hold_between: assert property (!periodEnd[1] |=> $stable(result_r[1]))
    else $error("result changed mid period");

  chk_hold_ch0: assert property (!periodEnd[0] |=> $stable(result_r[0]))
    else $error("channel 0 changed mid period");

  chk_read_pulse: assert property (readEnable |=> readValid)
    else $error("read not answered");

  chk_valid_quiet: assert property (!readEnable |=> !readValid)
    else $error("answer without request");

  chk_unmapped_zero: assert property (readEnable && readAddress != `ADDR_RESULT_CH0
    && readAddress != `ADDR_RESULT_CH1 |=> readData == 16'h0000)
    else $error("unmapped word not zero");

  chk_apply_code0: assert property (readEnable && applying
    && readAddress == `ADDR_RESULT_CH0 |=> readData == 16'h7fff)
    else $error("apply code not shown on channel 0");

  chk_record_other: assert property (parmWrite && parmRecordNum != 8'h01
    |-> !parmAccepted)
    else $error("foreign record accepted");

  chk_pending_take: assert property (parmAccepted
    |=> pendingSel_r == $past(parmByte1))
    else $error("pending select not taken");

  chk_default_sel: assert property (!configured_r
    |-> filterSel_r == `FILTER_SELECT_RESET)
    else $error("default select lost");

  chk_period_restart: assert property (applying
    |=> periodCnt_r[0] == 32'd0 && periodCnt_r[1] == 32'd0)
    else $error("period not restarted");

  chk_sign_pos: assert property (periodEnd[0] && !paramInvalid
    && filt_r[0] >= 0 |=> !result_r[0][`SIGN_BIT])
    else $error("positive value with sign bit");

  chk_over_sat1: assert property (periodEnd[1] && !paramInvalid
    && filt_r[1] > 16'sd11759 |=> result_r[1] == 16'h7fff)
    else $error("overflow code missing on channel 1");

  chk_under_sat0: assert property (periodEnd[0] && !paramInvalid
    && filt_r[0] < -16'sd800 |=> result_r[0] == 16'h8000)
    else $error("underflow code missing on channel 0");

  chk_invalid_ch1: assert property (periodEnd[1] && paramInvalid
    |=> result_r[1] == 16'h7fff)
    else $error("invalid parameter code missing on channel 1");

endmodule

// ### tb/user_program_model.sv
`timescale 1ns/10ps
module user_program_model (
  input wire logic clock,
  input wire logic parmAccepted,
  output logic parmWrite,
  output logic [7:0] parmRecordNum,
  output logic [7:0] parmByte0,
  output logic [7:0] parmByte1
);
  initial begin
    parmWrite = 1'b0;
    parmRecordNum = 8'h00;
    parmByte0 = 8'h00;
    parmByte1 = 8'h00;
  end
  // Fields scrambled after release so stale values never pass
  task automatic sendRecord(input logic [7:0] num, input logic [7:0] sel, output logic acc);
    @(negedge clock);
    parmWrite = 1'b1;
    parmRecordNum = num;
    parmByte0 = 8'h00;
    parmByte1 = sel;
    @(posedge clock);
    acc = parmAccepted;
    @(negedge clock);
    parmWrite = 1'b0;
    parmRecordNum = ~num;
    parmByte0 = 8'hff;
    parmByte1 = ~sel;
  endtask
endmodule

// ### tb/analog_input_readout_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin fails++; \
  $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module analog_input_readout_tb_top;
  import analog_input_readout_pkg::*;
  localparam int AP = 10;
  logic clock = 0, reset = 1, sampleValid = 0, sampleChannel = 0, readEnable = 0, acc;
  logic signed [15:0] sampleMilliVolts = '0;
  logic [15:0] readAddress = '0;
  wire logic parmWrite, parmAccepted, applying, readValid;
  wire logic [7:0] parmRecordNum, parmByte0, parmByte1;
  wire logic [15:0] readData;
  int fails = 0, checks_done = 0, filt[2] = '{0, 0}, k, mv;
  int corner[5] = '{15000, 10000, -3000, -3000, 15000};
  logic [31:0] seed = 32'd54647;
  logic badParm = 0;
  logic ch;
  analog_input_readout #(.INT_CYC0(20), .INT_CYC1(30), .INT_CYC2(40), .INT_CYC3(50),
    .DEFAULT_CYC(60), .APPLY_CYC(AP)) u_analog_input_readout (.clock(clock), .reset(reset),
    .sampleValid(sampleValid), .sampleChannel(sampleChannel),
    .sampleMilliVolts(sampleMilliVolts), .parmWrite(parmWrite), .parmRecordNum(parmRecordNum),
    .parmByte0(parmByte0), .parmByte1(parmByte1), .parmAccepted(parmAccepted),
    .applying(applying), .readEnable(readEnable), .readAddress(readAddress),
    .readData(readData), .readValid(readValid));
  user_program_model u_user_program_model (.clock(clock), .parmAccepted(parmAccepted),
    .parmWrite(parmWrite), .parmRecordNum(parmRecordNum), .parmByte0(parmByte0),
    .parmByte1(parmByte1));
  initial begin
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] expCode(int v);
    if (badParm) return 16'h7fff;
    if (v > 11759) return 16'h7fff;
    if (v < -800) return 16'h8000;
    return 16'((v * 27648) / 10000) & 16'hfff0;
  endfunction
  task automatic rd(input logic [15:0] a, input logic [15:0] ex, input string nm);
    @(negedge clock);
    readEnable = 1;
    readAddress = a;
    @(negedge clock);
    readEnable = 0;
    readAddress = ~a;
    `CHK("readValid", 1'b1, readValid)
    `CHK(nm, ex, readData)
  endtask
  task automatic smp(input logic c, input int v);
    @(negedge clock);
    sampleValid = 1;
    sampleChannel = c;
    sampleMilliVolts = 16'(v);
    filt[c] += (v - filt[c]) >>> 3;
    @(negedge clock);
    sampleValid = 0;
    sampleChannel = ~c;
    sampleMilliVolts = ~sampleMilliVolts;
  endtask
  task automatic waitApply(output int n);
    n = 0;
    while (applying === 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    `CHK("applyDone", 1'b0, applying)
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(25ns * 8000);
    fails++;
    end_sim();
  end
  initial begin
    repeat (6) @(negedge clock);
    reset = 0;
    rd(16'h0320, 16'h0000, "resetCh0");
    rd(16'h0324, 16'h0000, "unmapped");
    u_user_program_model.sendRecord(8'h02, 8'h00, acc);
    `CHK("accRec2", 1'b0, acc)
    `CHK("applyRec2", 1'b0, applying)
    u_user_program_model.sendRecord(8'h01, 8'h10, acc);
    `CHK("accRec1", 1'b1, acc)
    rd(16'h0322, 16'h7fff, "applyRead");
    waitApply(k);
    `CHK("applyLen", AP + 1, k + 3)
    // Corners first; 80 samples let the filter land exactly when coming from above
    for (int r = 0; r < 12; r++) begin
      ch = (r < 5) ? (r >= 3) : rnd() % 2 != 0;
      mv = (r < 5) ? corner[r] : int'(rnd() % 14000) - 1000;
      repeat (80) smp(ch, mv);
      repeat (70) @(negedge clock);
      rd(16'h0320, expCode(filt[0]), "ch0");
      rd(16'h0322, expCode(filt[1]), "ch1");
    end
    u_user_program_model.sendRecord(8'h01, 8'h20, acc);
    waitApply(k);
    badParm = 1;
    repeat (70) @(negedge clock);
    rd(16'h0320, expCode(filt[0]), "badCh0");
    rd(16'h0322, expCode(filt[1]), "badCh1");
    badParm = 0;
    u_user_program_model.sendRecord(8'h01, 8'h0c, acc);
    waitApply(k);
    smp(1'b0, 7000);
    smp(1'b1, 3000);
    repeat (22) @(negedge clock);
    rd(16'h0320, expCode(filt[0]), "fastCh0");
    // Slow period not over yet: the invalid-phase code still stands
    rd(16'h0322, 16'h7fff, "slowCh1");
    repeat (30) @(negedge clock);
    rd(16'h0322, expCode(filt[1]), "slowCh1New");
    end_sim();
  end
endmodule
